// ===== tppwm_defines.vh
// Purpose: Constants for the three-phase PWM engine.
// Assumes: 100 MHz system clock; register indexes are local to the motor register space.
// Notes:   Offsets are register indexes on the engine's own register port.
`ifndef TPPWM_DEFINES_VH
`define TPPWM_DEFINES_VH
`define TPPWM_REG_CARRIER_CONTROL 4'h0
`define TPPWM_REG_PERIOD_LOW      4'h1
`define TPPWM_REG_PERIOD_HIGH     4'h2
`define TPPWM_REG_DUTY_HIGH       4'h3
`define TPPWM_REG_DUTY_LOW        4'h4
`define TPPWM_REG_MOTOR_CONTROL   4'h5
`define TPPWM_REG_HALL_VALUE      4'h6
`define TPPWM_REG_LEAD_ANGLE      4'h7
`define TPPWM_REG_STATUS          4'h8
`define TPPWM_REG_PORT0_SELECT    4'h9
`define TPPWM_REG_USER_TABLE      4'hA
`define TPPWM_REG_WAVE_TABLE      4'hB
`define TPPWM_REG_DEBOUNCE        4'hC
`define TPPWM_SHAPE_UP            2'h0
`define TPPWM_SHAPE_DOWN          2'h1
`define TPPWM_SHAPE_UPDOWN        2'h2
`define TPPWM_CTL_DIR             0
`define TPPWM_CTL_HALL_REG        1
`define TPPWM_CTL_USER_TABLE      2
`define TPPWM_CTL_HALL_INVERT     3
`define TPPWM_CTL_AUTO_SINE       4
`define TPPWM_CTL_USER_WAVE       5
`define TPPWM_CTL_FORCE_SINE      6
`define TPPWM_PORT0_RESET         8'h00
`define TPPWM_PERIOD_RESET        11'h3FF
`define TPPWM_LOCK_EDGES          4'h6
`define TPPWM_BLANK_CYCLES        8'h20
`endif

// ===== tppwm_engine.v
// Purpose: Carrier, square-wave, sine-wave, angle predictor and port-0 select.
// Assumes: Hall inputs are asynchronous; register port is on the system clock.
// Notes:   Phase order is hs1 hs2 hs3 ls1 ls2 ls3 in bits 0 to 5.
`timescale 1ns/1ps
`include "tppwm_defines.vh"
// Functional notes
// (RQ1) Carrier counts up, down or up-down by the shape field.
// (RQ2) Up-down period is prescale times postscale times period times two.
// (RQ3) Up or down period is prescale times postscale times period.
// (RQ4) Square wave follows Hall pins or Hall register; direction picks table half.
// (RQ5) Hall code zero or seven drives all six outputs low.
// (RQ6) Direction one uses its fixed commutation table.
// (RQ7) Direction zero uses its fixed commutation table.
// (RQ8) P gives PWM, complement entry gives inverse, 1 and 0 are constants.
// (RQ9) A user square-wave table can replace the default table.
// (RQ10) Square-wave duty is the 11-bit high and low duty parts.
// (RQ11) Sine wave uses space vector modulation from built-in or user waveform.
// (RQ12) Sine-wave duty comes from the duty high part only.
// (RQ13) Start in square wave, switch to sine once angle prediction locks.
// (RQ14) Sine outputs follow estimated angle, direction sets phase order.
// (RQ15) Hall inputs are debounced, blanked, regulated and optionally inverted.
// (RQ16) A programmable leading angle is added to estimated position.
// (RQ17) Port-0 select bit 0 routes phase output, 1 routes general I/O.
// (RQ18) Port-0 select resets to zero so pins carry phase outputs.
// (RQ19) Settings live in motor register space reached by register port.
// (RQ20) Hall error turns all outputs off until the error clears.
// (RQ21) Output mux selects square or sine outputs by active mode.
// (RQ22) Counter advances per scaled tick; PWM high while counter below duty.
module tppwm_engine (
    input  wire        clock,
    input  wire        resetn,
    input  wire        reg_write,
    input  wire        reg_read,
    input  wire [3:0]  reg_index,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    input  wire [2:0]  hall_pins,
    input  wire [5:0]  gpio_out,
    output wire [5:0]  port0_pins,
    output wire        sine_active,
    output wire        hall_error
);
    reg  [7:0]  carrier_control_reg;
    reg  [10:0] carrier_period;
    reg  [7:0]  duty_high_part;
    reg  [2:0]  duty_low_part;
    reg  [7:0]  motor_control;
    reg  [2:0]  hall_value;
    reg  [7:0]  lead_angle;
    reg  [7:0]  port_zero_function_select;
    reg  [7:0]  debounce_len;
    reg  [5:0]  user_table [0:15];
    reg  [7:0]  user_wave [0:63];
    reg  [2:0]  tbl_ptr;
    reg  [5:0]  wave_ptr;
    integer     i;
    wire [1:0]  carrier_shape_select = carrier_control_reg[1:0];
    wire [1:0]  carrier_prescale     = carrier_control_reg[3:2];
    wire [2:0]  carrier_postscale    = carrier_control_reg[6:4];
    wire        rotation_direction   = motor_control[`TPPWM_CTL_DIR];
    // Register writes, all settings in motor register space.
    always @(posedge clock) begin
        if (!resetn) begin
            carrier_control_reg       <= 8'h00;
            carrier_period            <= `TPPWM_PERIOD_RESET;
            duty_high_part            <= 8'h00;
            duty_low_part             <= 3'h0;
            motor_control             <= 8'h10;
            hall_value                <= 3'h0;
            lead_angle                <= 8'h00;
            port_zero_function_select <= `TPPWM_PORT0_RESET; // RQ18
            debounce_len              <= 8'h04;
            tbl_ptr                   <= 3'h0;
            wave_ptr                  <= 6'h00;
            for (i = 0; i < 16; i = i + 1) begin
                user_table[i] <= 6'h00;
            end
        end else if (reg_write) begin
            case (reg_index) // RQ19
                `TPPWM_REG_CARRIER_CONTROL: carrier_control_reg <= reg_wdata;
                `TPPWM_REG_PERIOD_LOW:  carrier_period[7:0]  <= reg_wdata;
                `TPPWM_REG_PERIOD_HIGH: carrier_period[10:8] <= reg_wdata[2:0];
                `TPPWM_REG_DUTY_HIGH:   duty_high_part <= reg_wdata;
                `TPPWM_REG_DUTY_LOW:    duty_low_part  <= reg_wdata[2:0];
                `TPPWM_REG_MOTOR_CONTROL: motor_control <= reg_wdata;
                `TPPWM_REG_HALL_VALUE:  hall_value <= reg_wdata[2:0];
                `TPPWM_REG_LEAD_ANGLE:  lead_angle <= reg_wdata;
                `TPPWM_REG_PORT0_SELECT: port_zero_function_select <= reg_wdata; // RQ17
                `TPPWM_REG_DEBOUNCE:    debounce_len <= reg_wdata;
                `TPPWM_REG_USER_TABLE: begin
                    user_table[{rotation_direction, tbl_ptr}] <= reg_wdata[5:0]; // RQ9
                    tbl_ptr <= tbl_ptr + 3'h1;
                end
                `TPPWM_REG_WAVE_TABLE: begin
                    wave_ptr <= wave_ptr + 6'h01;
                end
                default: begin
                end
            endcase
        end
    end
    always @(posedge clock) begin
        if (reg_write && reg_index == `TPPWM_REG_WAVE_TABLE) begin
            user_wave[wave_ptr] <= reg_wdata; // RQ11
        end
    end
    // Carrier prescale, postscale and counter.
    reg  [1:0]  pre_cnt;
    reg  [2:0]  post_cnt;
    reg  [10:0] saw;
    reg         saw_down;
    wire [1:0]  pre_lim  = (carrier_prescale == 2'h0) ? 2'h0 : carrier_prescale - 2'h1;
    wire [2:0]  post_lim = (carrier_postscale == 3'h0) ? 3'h0 : carrier_postscale - 3'h1;
    wire        pre_tick = (pre_cnt >= pre_lim);
    wire        tick     = pre_tick && (post_cnt >= post_lim);
    wire [10:0] per_m1   = (carrier_period == 11'h000) ? 11'h000 : carrier_period - 11'h001;
    reg         cycle_start;
    always @(posedge clock) begin
        if (!resetn) begin
            pre_cnt     <= 2'h0;
            post_cnt    <= 3'h0;
            saw         <= 11'h000;
            saw_down    <= 1'b0;
            cycle_start <= 1'b0;
        end else begin
            pre_cnt     <= pre_tick ? 2'h0 : pre_cnt + 2'h1;
            post_cnt    <= tick ? 3'h0 : (pre_tick ? post_cnt + 3'h1 : post_cnt);
            cycle_start <= 1'b0;
            if (tick) begin // RQ22
                case (carrier_shape_select) // RQ1
                    `TPPWM_SHAPE_DOWN: begin // RQ3
                        saw <= (saw == 11'h000) ? per_m1 : saw - 11'h001;
                        cycle_start <= (saw == 11'h000);
                    end
                    `TPPWM_SHAPE_UPDOWN: begin // RQ2
                        if (!saw_down && saw >= carrier_period) begin
                            saw_down <= 1'b1;
                            saw      <= saw - 11'h001;
                        end else if (saw_down && saw == 11'h000) begin
                            saw_down    <= 1'b0;
                            saw         <= 11'h001;
                            cycle_start <= 1'b1;
                        end else begin
                            saw <= saw_down ? saw - 11'h001 : saw + 11'h001;
                        end
                    end
                    default: begin // RQ3
                        saw <= (saw >= per_m1) ? 11'h000 : saw + 11'h001;
                        cycle_start <= (saw >= per_m1);
                    end
                endcase
            end
        end
    end
    // Hall filter: sync, invert, debounce, blank, regulate.
    reg  [2:0]  hall_s1;
    reg  [2:0]  hall_s2;
    reg  [2:0]  hall_cand;
    reg  [7:0]  stable_cnt;
    reg  [7:0]  blank_cnt;
    reg  [2:0]  hall_filt;
    wire [2:0]  hall_inv = hall_s2 ^ {3{motor_control[`TPPWM_CTL_HALL_INVERT]}};
    always @(posedge clock) begin
        if (!resetn) begin
            hall_s1    <= 3'h0;
            hall_s2    <= 3'h0;
            hall_cand  <= 3'h0;
            stable_cnt <= 8'h00;
            blank_cnt  <= 8'h00;
            hall_filt  <= 3'h0;
        end else begin
            hall_s1 <= hall_pins;
            hall_s2 <= hall_s1;
            if (hall_inv != hall_cand) begin // RQ15
                hall_cand  <= hall_inv;
                stable_cnt <= 8'h00;
            end else if (stable_cnt < debounce_len) begin
                stable_cnt <= stable_cnt + 8'h01;
            end
            if (blank_cnt != 8'h00) begin
                blank_cnt <= blank_cnt - 8'h01;
            end else if (stable_cnt >= debounce_len && hall_cand != hall_filt) begin
                hall_filt <= hall_cand;
                blank_cnt <= `TPPWM_BLANK_CYCLES;
            end
        end
    end
    wire [2:0] hall_code = motor_control[`TPPWM_CTL_HALL_REG] ? hall_value : hall_filt; // RQ4
    assign hall_error = (hall_code == 3'h0) || (hall_code == 3'h7);
    // Angle predictor: sector from Hall, interpolate by sector period.
    reg  [2:0]  sector;
    always @* begin
        case (hall_code)
            3'h1: sector = 3'h0;
            3'h3: sector = 3'h1;
            3'h2: sector = 3'h2;
            3'h6: sector = 3'h3;
            3'h4: sector = 3'h4;
            3'h5: sector = 3'h5;
            default: sector = 3'h0;
        endcase
    end
    reg  [2:0]  last_sector;
    reg  [19:0] sect_timer;
    reg  [19:0] sect_period;
    reg  [19:0] step_acc;
    reg  [5:0]  sub_angle;
    reg  [3:0]  lock_cnt;
    always @(posedge clock) begin
        if (!resetn) begin
            last_sector <= 3'h0;
            sect_timer  <= 20'h0_0000;
            sect_period <= 20'hF_FFFF;
            step_acc    <= 20'h0_0000;
            sub_angle   <= 6'h00;
            lock_cnt    <= 4'h0;
        end else if (hall_error) begin
            lock_cnt <= 4'h0;
        end else if (sector != last_sector) begin
            last_sector <= sector;
            sect_period <= sect_timer;
            sect_timer  <= 20'h0_0000;
            step_acc    <= 20'h0_0000;
            sub_angle   <= 6'h00;
            if (lock_cnt != `TPPWM_LOCK_EDGES) begin
                lock_cnt <= lock_cnt + 4'h1;
            end
        end else begin
            if (sect_timer != 20'hF_FFFF) begin
                sect_timer <= sect_timer + 20'h0_0001;
            end
            if (step_acc + 20'h0_0040 >= sect_period) begin
                step_acc <= 20'h0_0000;
                if (sub_angle != 6'h3F) begin
                    sub_angle <= sub_angle + 6'h01;
                end
            end else begin
                step_acc <= step_acc + 20'h0_0040;
            end
        end
    end
    wire [8:0] raw_angle = {sector, 6'h00} + {3'h0, sub_angle};
    wire [9:0] lead_sum  = {1'b0, raw_angle} + {2'b00, lead_angle}; // RQ16
    wire [8:0] angle     = (lead_sum >= 10'd384) ? lead_sum[8:0] - 9'd384 : lead_sum[8:0];
    assign sine_active = motor_control[`TPPWM_CTL_FORCE_SINE] ||
                         (motor_control[`TPPWM_CTL_AUTO_SINE] &&
                          lock_cnt == `TPPWM_LOCK_EDGES); // RQ13
    // Modulated signals.
    wire [10:0] sq_duty   = {duty_high_part, duty_low_part}; // RQ10
    wire [10:0] sine_amp  = {duty_high_part, 3'h0}; // RQ12
    wire        pwm_sq    = (saw < sq_duty); // RQ22
    // Default square-wave table; entry code 0=zero 1=one 2=P 3=Pb.
    reg  [11:0] def_row;
    always @* begin
        case ({rotation_direction, hall_code})
            4'b1_001: def_row = 12'b00_01_11_00_00_10; // RQ6
            4'b1_011: def_row = 12'b11_01_00_10_00_00;
            4'b1_010: def_row = 12'b11_00_01_10_00_00;
            4'b1_110: def_row = 12'b00_11_01_00_10_00;
            4'b1_100: def_row = 12'b01_11_00_00_10_00;
            4'b1_101: def_row = 12'b01_00_11_00_00_10;
            4'b0_101: def_row = 12'b11_00_01_10_00_00; // RQ7
            4'b0_100: def_row = 12'b11_01_00_10_00_00;
            4'b0_110: def_row = 12'b00_01_11_00_00_10;
            4'b0_010: def_row = 12'b01_00_11_00_00_10;
            4'b0_011: def_row = 12'b01_11_00_00_10_00;
            4'b0_001: def_row = 12'b00_11_01_00_10_00;
            default:  def_row = 12'h000; // RQ5
        endcase
    end
    // User table: per output, bit g enables PWM, else the output is held low.
    wire [5:0] user_row = user_table[{rotation_direction, sector}];
    wire [5:0] sq_out;
    wire [5:0] sv_out;
    wire [8:0] ph_off [0:2];
    assign ph_off[0] = 9'd0;
    assign ph_off[1] = rotation_direction ? 9'd128 : 9'd256; // RQ14
    assign ph_off[2] = rotation_direction ? 9'd256 : 9'd128;
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_phase
            wire [1:0] ent = def_row[2*g+1:2*g];
            wire def_bit = (ent == 2'd2) ? pwm_sq : (ent == 2'd3) ? ~pwm_sq : ent[0]; // RQ8
            wire use_bit = user_row[g] ? pwm_sq : 1'b0;
            assign sq_out[g] = (motor_control[`TPPWM_CTL_USER_TABLE] && !hall_error) ?
                               use_bit : def_bit;
        end
        for (g = 0; g < 3; g = g + 1) begin : g_sine
            wire [9:0] s0 = {1'b0, angle} + {1'b0, ph_off[g]};
            wire [8:0] a  = (s0 >= 10'd384) ? s0[8:0] - 9'd384 : s0[8:0];
            wire [7:0] tri_v = (a < 9'd192) ? a[7:0] + 8'd32 : 8'd224 - (a[7:0] - 8'd192);
            wire [7:0] shape = motor_control[`TPPWM_CTL_USER_WAVE] ?
                               user_wave[a[8:3]] : tri_v;
            wire [18:0] prod = shape * sine_amp;
            wire pwm_ph = (saw < prod[18:8]); // RQ11
            assign sv_out[g]     = pwm_ph;
            assign sv_out[g + 3] = ~pwm_ph;
        end
    endgenerate
    reg [5:0] phase_out;
    always @(posedge clock) begin
        if (!resetn) begin
            phase_out <= 6'h00;
        end else if (hall_error) begin
            phase_out <= 6'h00; // RQ20
        end else begin
            phase_out <= sine_active ? sv_out : sq_out; // RQ21
        end
    end
    // Pin order bit0..5: hs1 ls1 hs2 ls2 hs3 ls3.
    wire [5:0] pin_phase = {phase_out[5], phase_out[2], phase_out[4],
                            phase_out[1], phase_out[3], phase_out[0]};
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_pin
            assign port0_pins[g] = port_zero_function_select[g + 2] ?
                                   gpio_out[g] : pin_phase[g]; // RQ17
        end
    endgenerate
    always @(posedge clock) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_index)
                `TPPWM_REG_CARRIER_CONTROL: reg_rdata <= carrier_control_reg;
                `TPPWM_REG_PERIOD_LOW:  reg_rdata <= carrier_period[7:0];
                `TPPWM_REG_PERIOD_HIGH: reg_rdata <= {5'h00, carrier_period[10:8]};
                `TPPWM_REG_DUTY_HIGH:   reg_rdata <= duty_high_part;
                `TPPWM_REG_DUTY_LOW:    reg_rdata <= {5'h00, duty_low_part};
                `TPPWM_REG_MOTOR_CONTROL: reg_rdata <= motor_control;
                `TPPWM_REG_HALL_VALUE:  reg_rdata <= {5'h00, hall_value};
                `TPPWM_REG_LEAD_ANGLE:  reg_rdata <= lead_angle;
                `TPPWM_REG_STATUS: reg_rdata <= {2'h0, saw_down, sine_active,
                                                 hall_error, hall_code};
                `TPPWM_REG_PORT0_SELECT: reg_rdata <= port_zero_function_select;
                `TPPWM_REG_DEBOUNCE:    reg_rdata <= debounce_len;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule // tppwm_engine

// ===== tppwm_checker.sv
// Purpose: Port-level checks for the three-phase PWM engine.
// Assumes: Select and control registers are shadowed from register writes.
// Notes:   Pins bit 0..5 are hs1 ls1 hs2 ls2 hs3 ls3.
`timescale 1ns/1ps
module tppwm_checker (
    input wire       clock,
    input wire       resetn,
    input wire       reg_write,
    input wire       reg_read,
    input wire [3:0] reg_index,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [2:0] hall_pins,
    input wire [5:0] gpio_out,
    input wire [5:0] port0_pins,
    input wire       sine_active,
    input wire       hall_error
);
    reg  [7:0] sh_sel;
    reg  [7:0] sh_ctl;
    wire [5:0] sel6 = sh_sel[7:2];
    wire [5:0] ph   = port0_pins & ~sel6;
    always @(posedge clock) begin
        if (!resetn) begin
            sh_sel <= 8'h00;
            sh_ctl <= 8'h10;
        end else if (reg_write) begin
            if (reg_index == 4'h9) sh_sel <= reg_wdata;
            if (reg_index == 4'h5) sh_ctl <= reg_wdata;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    AST_GPIO_ROUTE: assert property ((port0_pins & sel6) == (gpio_out & sel6))
        else $error("gpio routing wrong");
    AST_RESET_ZERO: assert property ($rose(resetn) |-> port0_pins == 6'h00)
        else $error("pins not low after reset");
    AST_RDATA_HOLD: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data moved without read");
    AST_UNMAPPED_ZERO: assert property (reg_read && reg_index >= 4'hD |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_SEL_READBACK: assert property (reg_read && !reg_write && reg_index == 4'h9
        |=> reg_rdata == sh_sel)
        else $error("select readback wrong");
    AST_STATUS_FLAGS: assert property (reg_read && reg_index == 4'h8 |=>
        reg_rdata[7:6] == 2'b00 && reg_rdata[4:3] == {$past(sine_active), $past(hall_error)})
        else $error("status flags wrong");
    AST_ERR_OFF: assert property (hall_error && $past(hall_error) |-> ph == 6'h00)
        else $error("outputs on during hall error");
    AST_PAIR_EXCL: assert property (!sh_ctl[2] && !$past(sh_ctl[2]) && !sine_active
        && !$past(sine_active) |-> ((ph[0] & ph[1]) | (ph[2] & ph[3]) | (ph[4] & ph[5])) == 1'b0)
        else $error("both sides of a phase high");
    AST_SINE_FORCE: assert property (reg_write && reg_index == 4'h5 && reg_wdata[6]
        |=> sine_active)
        else $error("forced sine not active");
endmodule // tppwm_checker

bind tppwm_engine tppwm_checker u_chk (.clock(clock), .resetn(resetn), .reg_write(reg_write),
    .reg_read(reg_read), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .hall_pins(hall_pins), .gpio_out(gpio_out), .port0_pins(port0_pins),
    .sine_active(sine_active), .hall_error(hall_error));

// ===== tppwm_hall_model.sv
// Purpose: Hall sensor model with an optional one-cycle bounce on each change.
// Assumes: Sensor outputs are clocked by the system clock.
// Notes:   The bounce shows the inverse code for one cycle.
`timescale 1ns/1ps
module tppwm_hall_model (
    input  wire       clock,
    input  wire [2:0] target,
    input  wire       bounce,
    output reg  [2:0] hall_pins
);
    reg [2:0] last;
    always @(posedge clock) begin
        last <= target;
        if (bounce && target != last) begin
            hall_pins <= ~target;
        end else begin
            hall_pins <= target;
        end
    end
endmodule // tppwm_hall_model

// ===== tppwm_engine_tb.sv
// Purpose: Self-checking bench for the three-phase PWM engine.
// Assumes: Debounce length is set to 4 before Hall traffic.
// Notes:   Seeded random stimulus with fixed corner cases.
`timescale 1ns/1ps
module tppwm_engine_tb;
    reg         clock;
    reg         resetn;
    reg         reg_write;
    reg         reg_read;
    reg  [3:0]  reg_index;
    reg  [7:0]  reg_wdata;
    wire [7:0]  reg_rdata;
    wire [2:0]  hall_pins;
    reg  [5:0]  gpio_out;
    wire [5:0]  port0_pins;
    wire        sine_active;
    wire        hall_error;
    reg  [2:0]  hall_target;
    reg         bounce;
    reg  [7:0]  rv;
    reg  [31:0] r;
    reg  [5:0]  e;
    integer     err_total, check_count, i, k, d, p, inv, sh, pre, post, per, duty, hi, lo, n;
    tppwm_engine u_tppwm_engine (.clock(clock), .resetn(resetn), .reg_write(reg_write),
        .reg_read(reg_read), .reg_index(reg_index), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .hall_pins(hall_pins), .gpio_out(gpio_out),
        .port0_pins(port0_pins), .sine_active(sine_active), .hall_error(hall_error));
    tppwm_hall_model u_tppwm_hall_model (.clock(clock), .target(hall_target),
        .bounce(bounce), .hall_pins(hall_pins));
    always #5 clock = ~clock;
    task report_and_stop;
        begin
            $display("checks=%0d errors=%0d", check_count, err_total);
            if (err_total == 0 && check_count > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [3:0] idx, input [7:0] data);
        begin
            @(posedge clock);
            reg_write <= 1'b1;
            reg_index <= idx;
            reg_wdata <= data;
            @(posedge clock);
            reg_write <= 1'b0;
        end
    endtask
    task rd(input [3:0] idx);
        begin
            @(posedge clock);
            reg_read <= 1'b1;
            reg_index <= idx;
            @(posedge clock);
            reg_read <= 1'b0;
            #1 rv = reg_rdata;
        end
    endtask
    task hall_set(input [2:0] c);
        begin
            @(posedge clock);
            r = $urandom;
            hall_target <= c;
            bounce <= r[0];
            repeat (120) @(posedge clock);
            #1;
        end
    endtask
    task do_reset;
        begin
            @(posedge clock);
            resetn <= 1'b0;
            repeat (5) @(posedge clock);
            resetn <= 1'b1;
        end
    endtask
    task meas;
        begin
            n = 0;
            hi = 0;
            lo = 0;
            while (port0_pins[0] !== 1'b0 && n < 5000) begin @(negedge clock); n = n + 1; end
            while (port0_pins[0] !== 1'b1 && n < 5000) begin @(negedge clock); n = n + 1; end
            while (port0_pins[0] === 1'b1 && n < 5000) begin @(negedge clock); hi = hi + 1; n = n + 1; end
            while (port0_pins[0] === 1'b0 && n < 5000) begin @(negedge clock); lo = lo + 1; n = n + 1; end
        end
    endtask
    function [5:0] exp_pins(input dd, input [2:0] c, input pp);
        reg [31:0] t;
        reg [1:0]  h, q;
        begin
            t = (dd ? 32'h097B_ED60 : 32'h06DE_B790) >> (c * 4);
            h = t[3:2];
            q = t[1:0];
            exp_pins = 6'h00;
            if (h != 2'd0) begin
                exp_pins[2*h-2] = pp;
                exp_pins[2*h-1] = ~pp;
                exp_pins[2*q-1] = 1'b1;
            end
        end
    endfunction
    initial begin
        repeat (80000) @(posedge clock);
        err_total = err_total + 1;
        report_and_stop;
    end
    initial begin
        clock = 0; resetn = 0; reg_write = 0; reg_read = 0; reg_index = 0; reg_wdata = 0;
        gpio_out = 0; hall_target = 0; bounce = 0; err_total = 0; check_count = 0;
        r = $urandom(32'h8645fc60);
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        rd(4'h9); chk({8'h00, rv}, 16'h0000);
        rd(4'h5); chk({8'h00, rv}, 16'h0010);
        chk({15'h0000, hall_error}, 16'h0001);
        chk({10'h000, port0_pins}, 16'h0000);
        for (k = 13; k < 16; k = k + 1) begin rd(k[3:0]); chk({8'h00, rv}, 16'h0000); end
        wr(4'hC, 8'h04);
        for (i = 0; i < 32; i = i + 1) begin
            d = i / 16;
            p = (i / 8) % 2;
            k = i % 8;
            r = $urandom;
            inv = r[1];
            gpio_out <= r[9:4];
            wr(4'h5, {4'h0, r[1], 2'b00, d[0]});
            wr(4'h3, p ? 8'hFF : 8'h00);
            wr(4'h4, p ? 8'h07 : 8'h00);
            hall_set(inv ? ~k[2:0] : k[2:0]);
            chk({10'h000, port0_pins}, {10'h000, exp_pins(d[0], k[2:0], p[0])});
            chk({15'h0000, hall_error}, {15'h0000, k == 0 || k == 7});
        end
        wr(4'h5, 8'h01);
        hall_set(3'd1);
        rd(4'h8);
        chk({8'h00, rv}, 16'h0001);
        for (i = 0; i < 4; i = i + 1) begin
            r = $urandom;
            e = r[7:2];
            wr(4'h9, r[7:0]);
            gpio_out <= r[13:8];
            @(posedge clock);
            #1 chk({10'h000, port0_pins}, {10'h000, (r[13:8] & e) | (exp_pins(1, 1, 1) & ~e)});
            rd(4'h9); chk({8'h00, rv}, {8'h00, r[7:0]});
        end
        wr(4'h9, 8'h00);
        wr(4'h6, 8'h04);
        wr(4'h5, 8'h03);
        repeat (2) @(posedge clock);
        #1 chk({10'h000, port0_pins}, {10'h000, exp_pins(1, 4, 1)});
        wr(4'h6, 8'h01);
        wr(4'hA, 8'h01);
        wr(4'h5, 8'h07);
        repeat (2) @(posedge clock);
        #1 chk({10'h000, port0_pins}, 16'h0001);
        for (i = 0; i < 6; i = i + 1) begin
            r = $urandom;
            sh = i % 3;
            pre = 1 + r[3:0] % 3;
            post = 1 + r[7:4] % 7;
            per = 4 + r[11:8] % 13;
            duty = 1 + r[15:12] % (per - 1);
            do_reset;
            wr(4'h0, 8'h7E);
            wr(4'h1, per[7:0]);
            wr(4'h2, {5'h00, per[10:8]});
            wr(4'h3, duty[10:3]);
            wr(4'h4, {5'h00, duty[2:0]});
            wr(4'h0, {1'b0, post[2:0], pre[1:0], sh[1:0]});
            wr(4'hC, 8'h04);
            wr(4'h5, 8'h01);
            wr(4'h9, 8'h00);
            hall_set(3'd1);
            meas;
            meas;
            chk(hi[15:0], pre * post * (sh == 2 ? 2 * duty - 1 : duty));
            chk(hi[15:0] + lo[15:0], pre * post * per * (sh == 2 ? 2 : 1));
        end
        wr(4'h5, 8'h11);
        for (i = 0; i < 12; i = i + 1) hall_set(i % 6 == 0 ? 3'd1 : i % 6 == 1 ? 3'd3 :
            i % 6 == 2 ? 3'd2 : i % 6 == 3 ? 3'd6 : i % 6 == 4 ? 3'd4 : 3'd5);
        chk({15'h0000, sine_active}, 16'h0001);
        rd(4'h8);
        chk({8'h00, rv & 8'hDF}, 16'h0015);
        hall_set(3'd7);
        chk({15'h0000, sine_active}, 16'h0000);
        chk({10'h000, port0_pins}, 16'h0000);
        wr(4'h5, 8'h40);
        #1 chk({15'h0000, sine_active}, 16'h0001);
        wr(4'h3, 8'h00);
        wr(4'h4, 8'h07);
        wr(4'h6, 8'h04);
        wr(4'h5, 8'h43);
        repeat (2) @(posedge clock);
        #1 chk({10'h000, port0_pins}, 16'h002A);
        report_and_stop;
    end
endmodule // tppwm_engine_tb
